//--- design/fuse_cfg_consts.svh
// Constants for the system fuse configuration decoder
`ifndef FUSE_CFG_CONSTS_SVH
`define FUSE_CFG_CONSTS_SVH
// Fuse space base in the data address space
`define FUSE_BASE_ADDR      16'h1280
// Register indices (offsets are all multiples of four: byte address = 4 * index)
`define IDX_CONFIG_0        8'h05
`define IDX_CONFIG_1        8'h06
`define IDX_APP_CODE_END          8'h07
`define IDX_BOOT_END        8'h08
`define IDX_LOCK            8'h0A
// Own registers
`define IDX_STATUS          8'h10
`define IDX_ERASE           8'h11
// Field positions
`define BIT_BOOT_SKIP       7
`define BIT_APP_SKIP        6
`define PIN_ROLE_HI         3
`define PIN_ROLE_LO         2
`define BIT_KEEP_EE         0
`define DLY_SEL_HI          2
`define DLY_SEL_LO          0
// Word index slice of the byte address
`define IDX_HI              9
`define IDX_LO              2
// Reset values of the decoded bytes
`define RST_CONFIG_0        8'hF6
`define RST_CONFIG_1        8'h07
`define RST_SKIP            1'b1
`define RST_KEEP_EE         1'b0
`define RST_DELAY_SEL       3'h7
`define RST_ZERO8           8'h00
`define RST_ZERO32          32'h0000_0000
// Lock code that opens the device
`define LOCK_OPEN_CODE      8'hC5
// Shared pin role codes
`define ROLE_GPIO           2'h0
`define ROLE_RESET          2'h1
`define ROLE_DEBUG          2'h2
`define ROLE_DEBUG_ALT      2'h3
// Flash section codes
`define SEC_BOOT            2'h0
`define SEC_APP             2'h1
`define SEC_DATA            2'h2
// Flash block size shift (256-byte blocks)
`define BLOCK_SHIFT         8
`define FLASH_TOP           17'h0_4000
// Start-up delay: 1 ms unit at 40 MHz
`define CLK_HZ              40000000
`define MS_UNIT             1
`define CYC_PER_MS          ((`CLK_HZ / 1000) * `MS_UNIT)
// HTRANS / HSIZE codes
`define HTRANS_NONSEQ       2'h2
`define HSIZE_WORD          3'h2
`endif

//--- design/fuse_cfg_pkg.sv
// Types for the system fuse configuration decoder
package fuse_cfg_pkg;
  typedef enum logic [1:0] {
    pin_gpio,
    pin_ext_reset,
    pin_debug,
    pin_debug_alt_reset
  } pin_role_t;

  typedef struct packed {
    logic       boot_check_skip;
    logic       app_check_skip;
    logic [1:0] shared_pin_role;
    logic       keep_eeprom_on_erase;
    logic [2:0] startup_delay_sel;
    logic [7:0] app_code_end;
    logic [7:0] boot_section_end;
    logic [7:0] device_lock_code;
  } fuse_image_t;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] idx;
  } bus_req_t;

  typedef enum logic [1:0] {
    st_load,
    st_crc,
    st_delay,
    st_run
  } boot_state_t;
endpackage

//--- design/system_fuse_config_decoder.sv
// System fuse configuration decoder with AHB-Lite register slave
//
// Contract
// - Boot-section CRC runs before reset release unless boot check skip is set.
// - Application-code CRC runs before reset release unless app check skip is set.
// - Pin role codes 0,1,2 give GPIO, external reset, single-pin debug.
// - Code 3 gives debug plus alternate reset on largest package only, else reserved.
// - Unlocked chip erase keeps EEPROM when keep bit is 1, erases at 0.
// - Locked chip erase always erases EEPROM.
// - Start-up delay is 0 ms at code 0, doubling from 1 ms to 64 ms.
// - Application code end is the field times 256 bytes.
// - Application end of zero makes flash from boot end to top application code.
// - Flash above application end is application data.
// - Boot end is the field times 256 bytes from flash start.
// - Boot end of zero makes the whole flash boot section.
// - While locked, the debug port is kept off the system bus.
// - Fuse bytes appear in data space at base 0x1280, each at its offset.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"

module system_fuse_config_decoder
  import fuse_cfg_pkg::*;
#(
  parameter int unsigned DELAY_UNIT_CYCLES = `CYC_PER_MS,
  parameter bit          LARGE_PACKAGE     = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  nv_config_0,
  input  wire logic [7:0]  nv_config_1,
  input  wire logic [7:0]  nv_app_code_end,
  input  wire logic [7:0]  nv_boot_end,
  input  wire logic [7:0]  nv_lock,
  input  wire logic        sys_reset_req,
  input  wire logic        crc_done,
  input  wire logic        chip_erase_req,
  input  wire logic [16:0] flash_addr,
  output logic             crc_boot_run,
  output logic             crc_app_run,
  output logic             reset_release,
  output logic [1:0]       shared_pin_role,
  output logic             ext_reset_pin_en,
  output logic             alt_reset_pin_en,
  output logic             debug_port_en,
  output logic             debug_bus_allow,
  output logic             eeprom_erase,
  output logic             flash_erase,
  output logic [1:0]       flash_section
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Section boundary in bytes from a 256-byte block count
  function automatic logic [16:0] block_to_addr(input logic [7:0] blocks);
    block_to_addr = {1'b0, blocks, 8'h00};
  endfunction

  // Start-up delay in milliseconds: zero, then doubling per code
  function automatic logic [6:0] delay_ms(input logic [2:0] sel);
    delay_ms = (sel == 3'h0) ? 7'h00 : 7'(7'h01 << (sel - 3'h1));
  endfunction

  // ****************************************************************
  // Fuse image capture
  // ****************************************************************

  fuse_image_t fuse;
  fuse_image_t next_fuse;
  logic        locked;

  // Sampled while the system reset request is high, frozen afterwards
  always_comb begin
    next_fuse = fuse;
    if (sys_reset_req) begin
      next_fuse.boot_check_skip      = nv_config_0[`BIT_BOOT_SKIP];
      next_fuse.app_check_skip       = nv_config_0[`BIT_APP_SKIP];
      next_fuse.shared_pin_role      = nv_config_0[`PIN_ROLE_HI:`PIN_ROLE_LO];
      next_fuse.keep_eeprom_on_erase = nv_config_0[`BIT_KEEP_EE];
      next_fuse.startup_delay_sel    = nv_config_1[`DLY_SEL_HI:`DLY_SEL_LO];
      next_fuse.app_code_end         = nv_app_code_end;
      next_fuse.boot_section_end     = nv_boot_end;
      next_fuse.device_lock_code     = nv_lock;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse.boot_check_skip      <= `RST_SKIP;
      fuse.app_check_skip       <= `RST_SKIP;
      fuse.shared_pin_role      <= `ROLE_RESET;
      fuse.keep_eeprom_on_erase <= `RST_KEEP_EE;
      fuse.startup_delay_sel    <= `RST_DELAY_SEL;
      fuse.app_code_end         <= `RST_ZERO8;
      fuse.boot_section_end     <= `RST_ZERO8;
      fuse.device_lock_code     <= `RST_ZERO8;
    end else begin
      fuse <= next_fuse;
    end
  end

  // Any code other than the open code locks; reset value therefore locks
  assign locked = (fuse.device_lock_code != `LOCK_OPEN_CODE);

  // ****************************************************************
  // Reset release sequence: CRC checks then start-up delay
  // ****************************************************************

  boot_state_t state;
  boot_state_t next_state;
  logic [31:0] dly_cnt;
  logic [31:0] next_dly_cnt;
  logic        next_crc_boot;
  logic        next_crc_app;
  logic        next_release;
  logic        crc_boot_q;
  logic        crc_app_q;

  always_comb begin
    next_state    = state;
    next_dly_cnt  = dly_cnt;
    next_crc_boot = 1'b0;
    next_crc_app  = 1'b0;
    next_release  = 1'b0;
    case (state)
      st_load: begin
        if (!sys_reset_req) begin
          next_crc_boot = !fuse.boot_check_skip;
          next_crc_app  = !fuse.app_check_skip;
          next_state    = (next_crc_boot || next_crc_app) ? st_crc : st_delay;
          next_dly_cnt  = 32'(delay_ms(fuse.startup_delay_sel)) * DELAY_UNIT_CYCLES;
        end
      end
      st_crc: begin
        next_crc_boot = crc_boot_q;
        next_crc_app  = crc_app_q;
        // Reset stays held until the scan reports done
        if (crc_done) begin
          next_crc_boot = 1'b0;
          next_crc_app  = 1'b0;
          next_state    = st_delay;
        end
      end
      st_delay: begin
        if (dly_cnt == `RST_ZERO32) begin
          next_state   = st_run;
          next_release = 1'b1;
        end else begin
          next_dly_cnt = dly_cnt - 32'h0000_0001;
        end
      end
      st_run: begin
        next_release = 1'b1;
      end
      default: next_state = st_load;
    endcase
    if (sys_reset_req) begin
      next_state   = st_load;
      next_release = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= st_load;
      dly_cnt       <= `RST_ZERO32;
      crc_boot_q    <= 1'b0;
      crc_app_q     <= 1'b0;
      reset_release <= 1'b0;
    end else begin
      state         <= next_state;
      dly_cnt       <= next_dly_cnt;
      crc_boot_q    <= next_crc_boot;
      crc_app_q     <= next_crc_app;
      reset_release <= next_release;
    end
  end

  assign crc_boot_run = crc_boot_q;
  assign crc_app_run  = crc_app_q;

  // ****************************************************************
  // Pin role, debug access, erase and flash section decode
  // ****************************************************************

  logic [1:0]  next_role;
  logic        next_ext_rst;
  logic        next_alt_rst;
  logic        next_dbg;
  logic        next_dbg_bus;
  logic        next_ee_erase;
  logic        next_fl_erase;
  logic [1:0]  next_section;
  logic [16:0] boot_top;
  logic [16:0] app_top;

  always_comb begin
    next_role    = fuse.shared_pin_role;
    next_ext_rst = 1'b0;
    next_alt_rst = 1'b0;
    next_dbg     = 1'b0;
    case (fuse.shared_pin_role)
      `ROLE_GPIO:  next_ext_rst = 1'b0;
      `ROLE_RESET: next_ext_rst = 1'b1;
      `ROLE_DEBUG: next_dbg     = 1'b1;
      default: begin
        // Reserved on smaller packages: treated as plain GPIO
        next_dbg     = LARGE_PACKAGE;
        next_alt_rst = LARGE_PACKAGE;
        if (!LARGE_PACKAGE) next_role = `ROLE_GPIO;
      end
    endcase
    next_dbg_bus  = next_dbg && !locked;
    // Locking overrides the keep bit
    next_ee_erase = chip_erase_req && (locked || !fuse.keep_eeprom_on_erase);
    next_fl_erase = chip_erase_req;
    // Section classification: 0 boot, 1 application code, 2 application data
    boot_top = block_to_addr(fuse.boot_section_end);
    app_top  = (fuse.app_code_end == `RST_ZERO8) ? `FLASH_TOP
             : block_to_addr(fuse.app_code_end);
    if (fuse.boot_section_end == `RST_ZERO8 || flash_addr < boot_top) begin
      next_section = `SEC_BOOT;
    end else if (flash_addr < app_top) begin
      next_section = `SEC_APP;
    end else begin
      next_section = `SEC_DATA;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_pin_role  <= `ROLE_RESET;
      ext_reset_pin_en <= 1'b0;
      alt_reset_pin_en <= 1'b0;
      debug_port_en    <= 1'b0;
      debug_bus_allow  <= 1'b0;
      eeprom_erase     <= 1'b0;
      flash_erase      <= 1'b0;
      flash_section    <= `SEC_BOOT;
    end else begin
      shared_pin_role  <= next_role;
      ext_reset_pin_en <= next_ext_rst;
      alt_reset_pin_en <= next_alt_rst;
      debug_port_en    <= next_dbg;
      debug_bus_allow  <= next_dbg_bus;
      eeprom_erase     <= next_ee_erase;
      flash_erase      <= next_fl_erase;
      flash_section    <= next_section;
    end
  end

  // ****************************************************************
  // AHB-Lite register slave (zero wait states)
  // ****************************************************************

  bus_req_t    req;
  bus_req_t    next_req;
  logic [31:0] next_rdata;
  logic [7:0]  lock_shadow;
  logic [7:0]  next_lock_shadow;

  // Address phase capture; byte address is four times the register index
  always_comb begin
    next_req.sel   = hsel && hready && (htrans == `HTRANS_NONSEQ) && (hsize == `HSIZE_WORD);
    next_req.write = hwrite;
    next_req.idx   = haddr[`IDX_HI:`IDX_LO];
  end

  // Read mux and the one writable byte; lock shadow is only read back at the erase index
  always_comb begin
    next_rdata       = `RST_ZERO32;
    next_lock_shadow = lock_shadow;
    if (req.sel && req.write && req.idx == `IDX_LOCK) begin
      next_lock_shadow = hwdata[7:0];
    end
    if (next_req.sel && !hwrite) begin
      if (next_req.idx == `IDX_CONFIG_0) begin
        next_rdata = {24'h0, fuse.boot_check_skip, fuse.app_check_skip, 2'h3,
                      fuse.shared_pin_role, 1'b1, fuse.keep_eeprom_on_erase};
      end else if (next_req.idx == `IDX_CONFIG_1) begin
        next_rdata = {29'h0, fuse.startup_delay_sel};
      end else if (next_req.idx == `IDX_APP_CODE_END) begin
        next_rdata = {24'h0, fuse.app_code_end};
      end else if (next_req.idx == `IDX_BOOT_END) begin
        next_rdata = {24'h0, fuse.boot_section_end};
      end else if (next_req.idx == `IDX_LOCK) begin
        next_rdata = {24'h0, fuse.device_lock_code};
      end else if (next_req.idx == `IDX_STATUS) begin
        next_rdata = {26'h0, locked, reset_release, state == st_crc, 1'b0,
                      flash_section};
      end else if (next_req.idx == `IDX_ERASE) begin
        next_rdata = {24'h0, lock_shadow};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req         <= '0;
      hrdata      <= `RST_ZERO32;
      lock_shadow <= `RST_ZERO8;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      req         <= next_req;
      hrdata      <= next_rdata;
      lock_shadow <= next_lock_shadow;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

endmodule // system_fuse_config_decoder

//--- verif/fuse_cfg_checker.sv
// Port-level assertions for the fuse configuration decoder
`timescale 1ns/1ps
module fuse_cfg_checker
  import fuse_cfg_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  nv_config_0,
  input wire logic [7:0]  nv_app_code_end,
  input wire logic [7:0]  nv_boot_end,
  input wire logic [7:0]  nv_lock,
  input wire logic        sys_reset_req,
  input wire logic        chip_erase_req,
  input wire logic [16:0] flash_addr,
  input wire logic        crc_boot_run,
  input wire logic        crc_app_run,
  input wire logic        reset_release,
  input wire logic [1:0]  shared_pin_role,
  input wire logic        debug_port_en,
  input wire logic        debug_bus_allow,
  input wire logic        eeprom_erase,
  input wire logic        flash_erase,
  input wire logic [1:0]  flash_section
);
  logic [1:0] exp_sec;
  logic [1:0] exp_role;
  // Reference section; a zero boot end wins over the code end
  always_comb begin
    exp_sec = 2'h2;
    if (nv_app_code_end == 8'h00 || flash_addr < {1'b0, nv_app_code_end, 8'h00}) exp_sec = 2'h1;
    if (nv_boot_end == 8'h00 || flash_addr < {1'b0, nv_boot_end, 8'h00}) exp_sec = 2'h0;
  end
  // Code 3 is reserved on the small package and falls back to plain I/O
  assign exp_role = (nv_config_0[3:2] == 2'h3 && !LARGE_PACKAGE) ? 2'h0 : nv_config_0[3:2];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Boot steps: fuse load ends, later reset is let go
  sequence seq_start;
    $fell(sys_reset_req);
  endsequence
  sequence seq_done;
    $rose(reset_release);
  endsequence
  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  boot_crc_a: assert property (seq_start ##0 !nv_config_0[7] |-> ##[1:2] crc_boot_run)
    else $error("boot check not started");
  app_crc_a: assert property (seq_start ##0 !nv_config_0[6] |-> ##[1:2] crc_app_run)
    else $error("app check not started");
  check_skip_a: assert property (
    !(nv_config_0[7] && crc_boot_run || nv_config_0[6] && crc_app_run))
    else $error("skipped check still requested");
  release_order_a: assert property (seq_done |-> !crc_boot_run && !crc_app_run)
    else $error("reset let go during a check");
  pin_role_a: assert property (reset_release |->
    shared_pin_role == exp_role && debug_port_en == exp_role[1])
    else $error("shared pin role wrong");
  ee_erase_a: assert property (chip_erase_req && reset_release |=>
    flash_erase && eeprom_erase == !(nv_lock == 8'hC5 && nv_config_0[0]))
    else $error("erase outputs wrong");
  section_a: assert property (
    reset_release |=> flash_section == $past(exp_sec))
    else $error("flash section wrong");
  locked_debug_a: assert property (
    reset_release && nv_lock != 8'hC5 |-> !debug_bus_allow)
    else $error("debug reaches bus while locked");
  hold_cfg_a: assert property (
    reset_release |=> reset_release && $stable(shared_pin_role))
    else $error("settings moved after boot");
endmodule // fuse_cfg_checker

bind system_fuse_config_decoder fuse_cfg_checker #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_chk (
  .hclk, .hresetn, .hreadyout, .hresp, .nv_config_0, .nv_app_code_end, .nv_boot_end, .nv_lock,
  .sys_reset_req, .chip_erase_req, .flash_addr, .crc_boot_run, .crc_app_run,
  .reset_release, .shared_pin_role, .debug_port_en, .debug_bus_allow, .eeprom_erase,
  .flash_erase, .flash_section);

//--- verif/fuse_nv_model.sv
// Fuse storage and check engine on the far side of the decoder
`timescale 1ns/1ps
module fuse_nv_model (
  input  wire logic        hclk,
  input  wire logic [39:0] image,
  input  wire logic [3:0]  crc_lat,
  input  wire logic        crc_boot_run,
  input  wire logic        crc_app_run,
  output logic      [7:0]  nv_config_0,
  output logic      [7:0]  nv_config_1,
  output logic      [7:0]  nv_app_code_end,
  output logic      [7:0]  nv_boot_end,
  output logic      [7:0]  nv_lock,
  output logic             crc_done
);
  logic [3:0] cnt;
  // Stored bytes are levels that move only when reprogrammed
  assign {nv_config_0, nv_config_1, nv_app_code_end, nv_boot_end, nv_lock} = image;
  // Answers crc_lat + 1 cycles after a run starts; a slow answer holds reset longer
  always_ff @(posedge hclk) begin
    if (!(crc_boot_run || crc_app_run) || crc_done) begin
      cnt      <= 4'h0;
      crc_done <= 1'b0;
    end else begin
      cnt      <= cnt + 4'h1;
      crc_done <= (cnt == crc_lat);
    end
  end
endmodule // fuse_nv_model

//--- verif/tb.sv
// Self-checking bench for the fuse configuration decoder
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module tb;
  localparam int U = 4;
  logic        hclk, hresetn, hwrite, sys_reset_req, chip_erase_req, seen_b, seen_a;
  logic        hreadyout, hresp, crc_boot_run, crc_app_run, reset_release, crc_done;
  logic        ext_reset_pin_en, alt_reset_pin_en, debug_port_en, debug_bus_allow;
  logic        eeprom_erase, flash_erase;
  logic [1:0]  htrans, shared_pin_role, flash_section;
  logic [3:0]  crc_lat;
  logic [7:0]  nv_config_0, nv_config_1, nv_app_code_end, nv_boot_end, nv_lock;
  logic [16:0] flash_addr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [39:0] image;
  int          miscompares, tests_run, cyc;
  // Short start-up unit keeps the longest delay code cheap
  system_fuse_config_decoder #(.DELAY_UNIT_CYCLES(U)) dut (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(`HSIZE_WORD), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .nv_config_0, .nv_config_1, .nv_app_code_end,
    .nv_boot_end, .nv_lock, .sys_reset_req, .crc_done, .chip_erase_req, .flash_addr,
    .crc_boot_run, .crc_app_run, .reset_release, .shared_pin_role, .ext_reset_pin_en,
    .alt_reset_pin_en, .debug_port_en, .debug_bus_allow, .eeprom_erase, .flash_erase,
    .flash_section);
  fuse_nv_model nv (.hclk, .image, .crc_lat, .crc_boot_run, .crc_app_run, .nv_config_0,
    .nv_config_1, .nv_app_code_end, .nv_boot_end, .nv_lock, .crc_done);
  // 40 MHz system clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge hclk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Full reset and fuse load, then count cycles until reset is let go
  task automatic boot(logic [39:0] img, logic [3:0] lat);
    image <= img;
    crc_lat <= lat;
    hresetn <= 1'b0;
    sys_reset_req <= 1'b1;
    tick(4);
    hresetn <= 1'b1;
    tick(3);
    sys_reset_req <= 1'b0;
    cyc = 0;
    seen_b = 1'b0;
    seen_a = 1'b0;
    while (reset_release !== 1'b1 && cyc < 2000) begin
      tick();
      cyc++;
      seen_b |= crc_boot_run;
      seen_a |= crc_app_run;
    end
    if (cyc >= 2000) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // One single transfer: address phase held until hready, then the data phase
  task automatic bus(logic wr, logic [7:0] idx, logic [31:0] wd);
    int k;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= `HTRANS_NONSEQ;
    k = 0;
    do begin tick(); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin tick(); k++; end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic t_delay();
    int ms;
    for (int s = 0; s < 8; s++) begin
      ms = (s == 0) ? 0 : (1 << (s - 1));
      boot({8'hC4, 5'h0, s[2:0], 16'h0, `LOCK_OPEN_CODE}, 4'h1);
      `CHK("start delay", 1'b1, cyc >= ms * U && cyc <= ms * U + 6)
      `CHK("no check run", 2'h0, {seen_b, seen_a})
    end
  endtask
  task automatic t_crc();
    for (int c = 0; c < 4; c++) begin
      boot({c[1:0], 6'h04, 8'h00, 16'h0, `LOCK_OPEN_CODE}, 4'(c * 4 + 1));
      `CHK("boot check", !c[1], seen_b)
      `CHK("app check", !c[0], seen_a)
    end
  endtask
  task automatic t_roles();
    for (int r = 0; r < 4; r++) begin
      boot({4'hC, r[1:0], 2'h0, 8'h00, 16'h0, `LOCK_OPEN_CODE}, 4'h1);
      `CHK("pin role", r[1:0], shared_pin_role)
      `CHK("reset pin", r == 1, ext_reset_pin_en)
      `CHK("alt reset", r == 3, alt_reset_pin_en)
      `CHK("debug port", r[1], debug_port_en)
    end
  endtask
  task automatic t_erase();
    for (int k = 0; k < 4; k++) begin
      boot({7'h64, k[0], 8'h00, 16'h0, (k[1] ? `LOCK_OPEN_CODE : 8'h3A)}, 4'h1);
      chip_erase_req <= 1'b1;
      tick();
      chip_erase_req <= 1'b0;
      tick();
      `CHK("eeprom erase", !(k[1] && k[0]), eeprom_erase)
      `CHK("flash erase", 1'b1, flash_erase)
      `CHK("debug access", k[1], debug_bus_allow)
    end
  endtask
  // Boot end, code end, address, section
  localparam logic [35:0] SECT [7] = '{36'h10_20_0FFF_0, 36'h10_20_1000_1,
    36'h10_20_1FFF_1, 36'h10_20_2000_2, 36'h00_20_3000_0, 36'h10_00_3FFF_1,
    36'h00_00_2000_0};
  task automatic t_sect();
    foreach (SECT[i]) begin
      boot({8'hC4, 8'h00, SECT[i][27:20], SECT[i][35:28], `LOCK_OPEN_CODE}, 4'h1);
      flash_addr <= {1'b0, SECT[i][19:4]};
      tick(2);
      `CHK("section", SECT[i][1:0], flash_section)
    end
  endtask
  // Index and expected word; index 3 is unmapped
  localparam logic [39:0] RDS [6] = '{40'h05_0000_00FB, 40'h06_0000_0001,
    40'h07_0000_0034, 40'h08_0000_0012, 40'h0A_0000_00C5, 40'h03_0000_0000};
  task automatic t_regs();
    boot({8'hC9, 8'h01, 8'h34, 8'h12, `LOCK_OPEN_CODE}, 4'h1);
    bus(1'b1, `IDX_CONFIG_0, 32'h0);
    foreach (RDS[i]) begin
      bus(1'b0, RDS[i][39:32], 32'h0);
      `CHK("register read", RDS[i][31:0], rd)
    end
    `CHK("debug open", 1'b1, debug_bus_allow)
    bus(1'b1, `IDX_LOCK, 32'h0000_003A);
    bus(1'b0, `IDX_ERASE, 32'h0);
    `CHK("lock shadow", 32'h0000_003A, rd)
    `CHK("lock held", 1'b1, debug_bus_allow)
  endtask
  // Main sequence; every scenario starts from its own reset
  initial begin
    {hresetn, hwrite, chip_erase_req, htrans, haddr, hwdata, flash_addr} = '0;
    sys_reset_req = 1'b1;
    image = 40'h0;
    crc_lat = 4'h1;
    miscompares = 0;
    tests_run = 0;
    t_delay();
    t_crc();
    t_roles();
    t_erase();
    t_sect();
    t_regs();
    end_of_test();
  end
endmodule // tb
